//--- logic/mrx_pkg.sv
package mrx_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  // Opcode patterns of the handled group
  localparam logic [13:0] OP_IDLE = 14'h0000;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETFI = 14'h0009;
  localparam logic [6:0] OP_STORE_HI = 7'h01;
  localparam logic [3:0] OP_LOADLIT_HI = 4'hc;
  localparam logic [3:0] OP_RETLIT_HI = 4'hd;
  localparam int IRQ_EN_BIT = 7;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] IRQCTL_RST = 8'h00;
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } exec_state_t;
endpackage

//--- logic/move_return_instr_exec.sv
`timescale 1ns/1ps
`default_nettype none
module move_return_instr_exec
  import mrx_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic instrValid,
  input wire logic [mrx_pkg::INSTR_W-1:0] instr,
  input wire logic [mrx_pkg::PC_W-1:0] stackTopEntry,
  output logic instrReady,
  output logic stackPop,
  output logic fileWrite,
  output logic [mrx_pkg::FADDR_W-1:0] fileAddr,
  output logic [mrx_pkg::DATA_W-1:0] fileData,
  output logic [mrx_pkg::DATA_W-1:0] acc,
  output logic [mrx_pkg::PC_W-1:0] pc,
  output logic [mrx_pkg::DATA_W-1:0] irqControlRegister,
  output logic globalIrqEnable,
  output logic illegalInstr
);
  import mrx_pkg::*;

  exec_state_t state_r, state_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [DATA_W-1:0] irqCtl_r, irqCtl_nxt;
  logic pop_r, pop_nxt;
  logic fWr_r, fWr_nxt;
  logic [FADDR_W-1:0] fAddr_r, fAddr_nxt;
  logic [DATA_W-1:0] fData_r, fData_nxt;
  logic ill_r, ill_nxt;
  logic ready_r, ready_nxt;
  logic isStore, isLoadLit, isRetLit, isIdle, isRet, isRetfi;

  // Full 14-bit compare on the no-operand forms so no stray code aliases
  assign isStore = instr[13:7] == OP_STORE_HI;
  assign isLoadLit = instr[13:10] == OP_LOADLIT_HI;
  assign isRetLit = instr[13:10] == OP_RETLIT_HI;
  assign isIdle = instr == OP_IDLE;
  assign isRet = instr == OP_RETURN;
  assign isRetfi = instr == OP_RETFI;

  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    pc_nxt = pc_r;
    irqCtl_nxt = irqCtl_r;
    pop_nxt = 1'b0;
    fWr_nxt = 1'b0;
    fAddr_nxt = fAddr_r;
    fData_nxt = fData_r;
    ill_nxt = 1'b0;
    case (state_r)
      ST_EXEC: begin
        // Ready gates the take, so a word offered early after reset waits
        if (instrValid && ready_r) begin
          if (isStore) begin
            fWr_nxt = 1'b1;
            fAddr_nxt = instr[FADDR_W-1:0];
            fData_nxt = acc_r;
            pc_nxt = pc_r + 13'h0001;
          end else if (isLoadLit) begin
            // Bits 9:8 ignored, so zero-filled code decodes too
            acc_nxt = instr[DATA_W-1:0];
            pc_nxt = pc_r + 13'h0001;
          end else if (isRetLit) begin
            acc_nxt = instr[DATA_W-1:0];
            pc_nxt = stackTopEntry;
            pop_nxt = 1'b1;
            state_nxt = ST_FLUSH;
          end else if (isRetfi) begin
            pc_nxt = stackTopEntry;
            pop_nxt = 1'b1;
            irqCtl_nxt[IRQ_EN_BIT] = 1'b1;
            state_nxt = ST_FLUSH;
          end else if (isRet) begin
            pc_nxt = stackTopEntry;
            pop_nxt = 1'b1;
            state_nxt = ST_FLUSH;
          end else if (isIdle) begin
            pc_nxt = pc_r + 13'h0001;
          end else begin
            // Outside this group: flagged, pc held for the owning unit
            ill_nxt = 1'b1;
          end
        end
      end
      // Second cycle of a return discards the prefetched word
      ST_FLUSH: state_nxt = ST_EXEC;
      default: state_nxt = ST_EXEC;
    endcase
    // Registered ready: low for the flush cycle that follows a return
    ready_nxt = (state_nxt == ST_EXEC);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_EXEC;
      acc_r <= ACC_RST;
      pc_r <= PC_RST;
      irqCtl_r <= IRQCTL_RST;
      pop_r <= 1'b0;
      fWr_r <= 1'b0;
      fAddr_r <= '0;
      fData_r <= '0;
      ill_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      pc_r <= pc_nxt;
      irqCtl_r <= irqCtl_nxt;
      pop_r <= pop_nxt;
      fWr_r <= fWr_nxt;
      fAddr_r <= fAddr_nxt;
      fData_r <= fData_nxt;
      ill_r <= ill_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign instrReady = ready_r;
  assign stackPop = pop_r;
  assign fileWrite = fWr_r;
  assign fileAddr = fAddr_r;
  assign fileData = fData_r;
  assign acc = acc_r;
  assign pc = pc_r;
  assign irqControlRegister = irqCtl_r;
  assign globalIrqEnable = irqCtl_r[IRQ_EN_BIT];
  assign illegalInstr = ill_r;

  // A return spends one more cycle with ready low; that word is dropped
  wire take = instrValid && ready_r && state_r == ST_EXEC;

  sequence retTaken_s;
    take && (isRet || isRetfi || isRetLit);
  endsequence
  sequence flushThenExec_s;
    state_r == ST_FLUSH ##1 state_r == ST_EXEC;
  endsequence

  store_write_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isStore |=> fileWrite && fileData == $past(acc_r)
      && fileAddr == $past(instr[6:0]) && acc_r == $past(acc_r))
    else $error("store did not write accumulator");
  store_pc_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isStore |=> pc_r == $past(pc_r) + 13'h0001 && !stackPop)
    else $error("store did not advance pc");
  loadlit_acc_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isLoadLit |=> acc_r == $past(instr[7:0])
      && pc_r == $past(pc_r) + 13'h0001 && state_r == ST_EXEC)
    else $error("literal load wrong");
  zero_dontcare_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && instr[13:8] == 6'h30 |=> !illegalInstr)
    else $error("zero-filled literal load refused");

  retfi_pop_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isRetfi |=> stackPop && pc_r == $past(stackTopEntry)
      ##0 flushThenExec_s)
    else $error("irq return pop wrong");
  retfi_irqen_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isRetfi |=> globalIrqEnable)
    else $error("irq return left interrupts off");
  retlit_acc_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isRetLit |=> acc_r == $past(instr[7:0]))
    else $error("literal return accumulator wrong");
  retlit_pc_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isRetLit |=> stackPop && pc_r == $past(stackTopEntry)
      ##0 flushThenExec_s)
    else $error("literal return pc wrong");
  ret_twocycle_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    retTaken_s |=> !instrReady ##1 instrReady)
    else $error("return not two cycles");
  flush_refuse_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    state_r == ST_FLUSH |=> $stable(acc_r) && $stable(pc_r)
      && !stackPop && !fileWrite && !illegalInstr)
    else $error("word taken in flush cycle");
  ret_keeps_irqen_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isRet |=> $stable(irqCtl_r) && pc_r == $past(stackTopEntry))
    else $error("subroutine return wrong");
  pop_single_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    stackPop |=> !stackPop)
    else $error("stack popped twice");

  idle_only_pc_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isIdle |=> $stable(acc_r) && !fileWrite && !stackPop
      && pc_r == $past(pc_r) + 13'h0001)
    else $error("idle changed state");
  idle_keeps_irq_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && isIdle |=> $stable(irqCtl_r) && state_r == ST_EXEC)
    else $error("idle touched irq control");
  outside_hold_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    take && !(isStore || isLoadLit || isRetLit || isRetfi || isRet || isIdle)
      |=> illegalInstr && $stable(pc_r) && $stable(acc_r)
      && !stackPop && !fileWrite)
    else $error("foreign word changed state");
endmodule
`default_nettype wire

//--- sim/move_return_instr_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module move_return_instr_exec_tb;
  import mrx_pkg::*;
  typedef struct {
    logic [13:0] w;
    logic [12:0] stk;
    logic [7:0] eAcc;
    logic [12:0] ePc;
    logic eFw;
    logic [6:0] eFa;
    logic ePop;
    logic eIen;
    logic eIll;
  } row_t;
  logic mclk, nrst, instrValid, instrReady, stackPop, fileWrite;
  logic globalIrqEnable, illegalInstr;
  logic [13:0] instr;
  logic [12:0] stackTopEntry, pc;
  logic [6:0] fileAddr;
  logic [7:0] fileData, acc, irqControlRegister;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  // Back-to-back words; returns followed by a refused word in the flush cycle
  row_t rows[10] = '{
    '{14'h305a, 13'h0000, 8'h5a, 13'h0001, 1'b0, 7'h00, 1'b0, 1'b0, 1'b0},
    '{14'h00ff, 13'h0000, 8'h5a, 13'h0002, 1'b1, 7'h7f, 1'b0, 1'b0, 1'b0},
    '{14'h0000, 13'h0000, 8'h5a, 13'h0003, 1'b0, 7'h00, 1'b0, 1'b0, 1'b0},
    '{14'h30ff, 13'h0000, 8'hff, 13'h0004, 1'b0, 7'h00, 1'b0, 1'b0, 1'b0},
    '{14'h0080, 13'h0000, 8'hff, 13'h0005, 1'b1, 7'h00, 1'b0, 1'b0, 1'b0},
    '{14'h34a5, 13'h1abc, 8'ha5, 13'h1abc, 1'b0, 7'h00, 1'b1, 1'b0, 1'b0},
    '{14'h0008, 13'h0123, 8'ha5, 13'h0123, 1'b0, 7'h00, 1'b1, 1'b0, 1'b0},
    '{14'h0009, 13'h1fff, 8'ha5, 13'h1fff, 1'b0, 7'h00, 1'b1, 1'b1, 1'b0},
    '{14'h0008, 13'h0040, 8'ha5, 13'h0040, 1'b0, 7'h00, 1'b1, 1'b1, 1'b0},
    '{14'h3fff, 13'h0000, 8'ha5, 13'h0040, 1'b0, 7'h00, 1'b0, 1'b1, 1'b1}
  };
  move_return_instr_exec i_dut (.mclk(mclk), .nrst(nrst),
    .instrValid(instrValid), .instr(instr), .stackTopEntry(stackTopEntry),
    .instrReady(instrReady), .stackPop(stackPop), .fileWrite(fileWrite),
    .fileAddr(fileAddr), .fileData(fileData), .acc(acc), .pc(pc),
    .irqControlRegister(irqControlRegister),
    .globalIrqEnable(globalIrqEnable), .illegalInstr(illegalInstr));
  always #2 mclk = ~mclk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 22 cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 300) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    instrValid = 1'b0;
    instr = 14'h0000;
    stackTopEntry = 13'h0000;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    check(16'(instrReady), 16'h0001);
    for (int i = 0; i < 10; i++) begin
      instrValid = 1'b1;
      instr = rows[i].w;
      stackTopEntry = rows[i].stk;
      @(negedge mclk);
      check(16'(acc), 16'(rows[i].eAcc));
      check(16'(pc), 16'(rows[i].ePc));
      check(16'(fileWrite), 16'(rows[i].eFw));
      if (rows[i].eFw) begin
        check(16'({fileAddr, fileData}), 16'({rows[i].eFa, rows[i].eAcc}));
      end
      check(16'(stackPop), 16'(rows[i].ePop));
      check(16'(globalIrqEnable), 16'(rows[i].eIen));
      check(16'(irqControlRegister), 16'({rows[i].eIen, 7'h00}));
      check(16'(illegalInstr), 16'(rows[i].eIll));
      if (rows[i].ePop) begin
        check(16'(instrReady), 16'h0000);
        instr = 14'h3011;
        stackTopEntry = ~rows[i].stk;
        @(negedge mclk);
        check(16'({acc, stackPop}), 16'({rows[i].eAcc, 1'b0}));
        check(16'({pc, instrReady}), 16'({rows[i].ePc, 1'b1}));
      end
    end
    $display("table test done");
    instr = 14'h3077;
    @(negedge mclk);
    check(16'(acc), 16'h0077);
    nrst = 1'b0;
    #1;
    check(16'({acc, instrReady, globalIrqEnable}), 16'h0000);
    check(16'(pc), 16'h0000);
    @(negedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    instr = 14'h0080;
    @(negedge mclk);
    check(16'({instrReady, fileWrite}), 16'h0002);
    instrValid = 1'b0;
    @(negedge mclk);
    check(16'({pc, fileWrite}), 16'h0000);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
